// ---- design/interrupt_flag_aggregator.sv ----
// Interrupt flag aggregator with a classic Wishbone register slave
// Function
// RULE1: Writing force bit one raises manual event
// RULE2: Manual mask gates forced event onto output
// RULE3: No second assertion while first still pending
// RULE4: Host reads every unmasked status after interrupt
// RULE5: Video core status at 0x43, 0x48, 0x5c
// RULE6: Level status bytes at 0x61 to 0x70
// RULE7: Edge status bytes at 0x7a to 0x8e
// RULE8: Overall raw is live, manual raw latched
// RULE9: Channel sync valid and lock events latch
// RULE10: Consumer control raw bits latch until cleared
// RULE11: Level raw bits follow live state
// RULE12: Edge raw bits latch until clear written
// RULE13: Sync valid select: rising only or both
// RULE14: Lock select: rising only or both edges
// RULE15: Lock status read-only at 0x43 bit 2
// RULE16: Masked change sets sticky status, clear releases
// RULE17: Duration field gives 4, 16, 64, hold
// RULE18: Manual force control at 0x40 bit 2
// RULE19: All masks cleared after reset
// RULE20: Output follows OR of unmasked status bits
`timescale 1ns/1ps
module interrupt_flag_aggregator
  import irq_agg_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [BUS_ADDR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       sync_valid_i,
  input  wire logic                       sync_valid_ch1_i,
  input  wire logic                       lock_i,
  input  wire logic                       lock_ch1_i,
  input  wire logic [N_LVL-1:0][7:0]      hdmi_level_raw_i,
  input  wire logic [N_EDGE-1:0][7:0]     hdmi_edge_evt_i,
  input  wire logic [5:0]                 consumer_ctl_evt_i,
  input  wire logic [7:0]                 consumer_ctl_event_byte_i,
  output logic                            irq_out_pin_o,
  output logic                            overall_irq_live_o
);
  // ==========================================================
  // Bus slave
  logic [7:0] idx;
  logic [7:0] wdat;
  logic       req;
  logic       wr;
  logic       ack_q;
  logic [7:0] rdat_q;
  logic [7:0] rd_d;

  assign idx  = wb_adr_i[9:2];
  assign wdat = wb_dat_i[7:0];
  assign req  = wb_cyc_i && wb_stb_i;
  // Write lands on the edge that also shows ack to the master
  assign wr   = req && wb_we_i && ack_q && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 8'h00;
    end else if (req && !ack_q) begin
      rdat_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, rdat_q};

  // ==========================================================
  // Control registers
  logic [7:0] ctrl_q;
  logic [7:0] edge_sel_q;
  logic       man_evt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST; // RULE1
    end else if (wr && idx == CTRL_IDX) begin
      ctrl_q <= wdat; // RULE18
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_sel_q <= EDGE_SEL_RST;
    end else if (wr && idx == EDGE_SEL_IDX) begin
      edge_sel_q <= wdat;
    end
  end

  // Every write of one fires an event, even if the mode is already on
  assign man_evt = wr && idx == CTRL_IDX && wdat[FORCE_BIT]; // RULE1

  // ==========================================================
  // Video core event detection
  logic [1:0] sync_evt;
  logic [3:0] lock_evt;

  edge_event_detect #(
    .W (2)
  ) u_sync_edge (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i ({sync_valid_ch1_i, sync_valid_i}),
    .both_i  (edge_sel_q[SYNC_SEL_BIT]), // RULE13
    .evt_o   (sync_evt)
  );

  // Lock and unlock are treated as two opposite live levels
  edge_event_detect #(
    .W (4)
  ) u_lock_edge (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i ({~lock_ch1_i, lock_ch1_i, ~lock_i, lock_i}),
    .both_i  (edge_sel_q[LOCK_SEL_BIT]), // RULE14
    .evt_o   (lock_evt)
  );

  // ==========================================================
  // Event sources per group
  logic [7:0] evt      [NUM_GROUPS];
  logic [7:0] raw_q    [NUM_GROUPS];
  logic [7:0] status_q [NUM_GROUPS];
  logic [7:0] mask_q   [NUM_GROUPS];
  logic [NUM_GROUPS-1:0] pend_bits;
  logic       pend;

  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      evt[g] = 8'h00;
    end
    evt[G_VC][VC_SYNC_BIT]   = sync_evt[0];
    evt[G_VC][VC_LOCK_BIT]   = lock_evt[0];
    evt[G_VC][VC_UNLOCK_BIT] = lock_evt[1];
    evt[G_CH][CH_SYNC_BIT]   = sync_evt[1]; // RULE9
    evt[G_CH][CH_LOCK_BIT]   = lock_evt[2]; // RULE9
    evt[G_CH][CH_UNLOCK_BIT] = lock_evt[3]; // RULE9
    evt[G_MAN][MANUAL_BIT]   = man_evt;
    for (int l = 0; l < N_LVL; l++) begin
      evt[G_LVL+l] = hdmi_level_raw_i[l] ^ raw_q[G_LVL+l]; // RULE11
    end
    for (int e = 0; e < N_EDGE; e++) begin
      evt[G_EDGE+e] = hdmi_edge_evt_i[e]; // RULE12
    end
    evt[G_CEC]  = {2'b00, consumer_ctl_evt_i}; // RULE10
    evt[G_CECB] = consumer_ctl_event_byte_i; // RULE10
  end

  // ==========================================================
  // Raw, status and mask per group
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : grp
    localparam logic [7:0] CLR_I  = STATUS_IDX[g] + CLR_DELTA;
    localparam logic [7:0] MASK_I = STATUS_IDX[g] + MASK_DELTA;
    logic [7:0] clr;

    // Self-clearing: the clear only lasts the write edge
    assign clr = (wr && idx == CLR_I) ? wdat : 8'h00;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mask_q[g] <= MASK_RST; // RULE19
      end else if (wr && idx == MASK_I) begin
        mask_q[g] <= wdat; // RULE2
      end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        status_q[g] <= 8'h00;
      end else begin
        status_q[g] <= (status_q[g] & ~clr) | (evt[g] & mask_q[g]); // RULE16
      end
    end

    if (g >= G_LVL && g < G_EDGE) begin : g_level
      // Live sample; no clear needed
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          raw_q[g] <= 8'h00;
        end else begin
          raw_q[g] <= hdmi_level_raw_i[g-G_LVL]; // RULE11
        end
      end
    end else begin : g_edge
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          raw_q[g] <= 8'h00;
        end else begin
          raw_q[g] <= (raw_q[g] & ~clr) | evt[g]; // RULE12
        end
      end
    end

    // Mask is applied again so masking a pending bit drops pend, and the pin only in hold mode
    assign pend_bits[g] = |(status_q[g] & mask_q[g]); // RULE20
  end

  assign pend               = |pend_bits; // RULE20
  assign overall_irq_live_o = pend; // RULE8

  // ==========================================================
  // Read multiplexer
  always_comb begin
    rd_d = 8'h00;
    if (idx == CTRL_IDX) begin
      rd_d = ctrl_q;
    end
    if (idx == EDGE_SEL_IDX) begin
      rd_d = edge_sel_q;
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (idx == STATUS_IDX[g]) begin
        rd_d = status_q[g]; // RULE15
      end
      if (idx == 8'(STATUS_IDX[g] - RAW_DELTA)) begin
        rd_d = raw_q[g];
        if (g == G_MAN) begin
          rd_d[LIVE_BIT] = pend; // RULE8
        end
      end
      if (idx == 8'(STATUS_IDX[g] + MASK_DELTA)) begin
        rd_d = mask_q[g];
      end
    end
  end

  // ==========================================================
  // Interrupt pin
  irq_pulse_shaper u_shaper (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pend_i (pend),
    .dur_i  (ctrl_q[DUR_LSB+:2]), // RULE17
    .irq_o  (irq_out_pin_o)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_FORCE_SETS_STATUS: // RULE1
    assert property (man_evt && mask_q[G_MAN][MANUAL_BIT] && !pend && !irq_out_pin_o
                     |=> status_q[G_MAN][MANUAL_BIT] && pend ##1 irq_out_pin_o)
    else $error("forced event did not reach status and pin");
  AST_FORCE_MASKED_OFF: // RULE2
    assert property (man_evt && !mask_q[G_MAN][MANUAL_BIT] && !status_q[G_MAN][MANUAL_BIT]
                     |=> !status_q[G_MAN][MANUAL_BIT])
    else $error("masked forced event set status");
  AST_MANUAL_RAW_LATCHED: // RULE8
    assert property ($fell(raw_q[G_MAN][MANUAL_BIT]) |-> $past(grp[G_MAN].clr[MANUAL_BIT]))
    else $error("manual raw bit dropped without clear");
  AST_EDGE_RAW_LATCHED: // RULE12
    assert property ($fell(raw_q[G_EDGE][0]) |-> $past(grp[G_EDGE].clr[0]))
    else $error("edge raw bit dropped without clear");
  AST_CONSUMER_LATCH: // RULE10
    assert property (consumer_ctl_event_byte_i[7] |=> raw_q[G_CECB][7])
    else $error("consumer control event not latched");
  AST_LEVEL_CHANGE: // RULE11
    assert property ($changed(hdmi_level_raw_i[0][1]) && mask_q[G_LVL][1] |=> status_q[G_LVL][1])
    else $error("level change did not set status");
  AST_STATUS_STICKY: // RULE16
    assert property (status_q[G_EDGE+1][1] && !grp[G_EDGE+1].clr[1] |=> status_q[G_EDGE+1][1])
    else $error("status released without clear");
  AST_LOCK_BOTH_EDGES: // RULE14
    assert property (edge_sel_q[LOCK_SEL_BIT] && $fell(lock_i) && mask_q[G_VC][VC_LOCK_BIT]
                     |=> status_q[G_VC][VC_LOCK_BIT])
    else $error("lock fall ignored in both-edge mode");
  AST_SYNC_RISE_ONLY: // RULE13
    assert property (!edge_sel_q[SYNC_SEL_BIT] && $fell(sync_valid_i) && !status_q[G_VC][VC_SYNC_BIT]
                     |=> !status_q[G_VC][VC_SYNC_BIT])
    else $error("sync fall raised status in rising-only mode");
  AST_MASKS_RESET: // RULE19
    assert property ($past(rst_i) |-> mask_q[G_MAN] == 8'h00 && mask_q[G_VC] == 8'h00 && !pend)
    else $error("mask not cleared by reset");
  AST_PIN_NEEDS_PENDING: // RULE20
    assert property ($rose(irq_out_pin_o) |-> $past(pend))
    else $error("pin rose with nothing pending");

  AST_SYNC_BOTH_EDGES: // RULE13
    assert property (edge_sel_q[SYNC_SEL_BIT] && $fell(sync_valid_i) && mask_q[G_VC][VC_SYNC_BIT]
                     |=> status_q[G_VC][VC_SYNC_BIT])
    else $error("sync fall ignored in both-edge mode");

  AST_STATUS_READ_ONLY: // RULE15
    assert property (wr && idx == STATUS_IDX[G_VC]
                     |=> status_q[G_VC] == ($past(status_q[G_VC]) | ($past(evt[G_VC]) & $past(mask_q[G_VC]))))
    else $error("write changed a read-only status");

  AST_FORCE_STORED: // RULE18
    assert property (wr && idx == CTRL_IDX |=> ctrl_q[FORCE_BIT] == $past(wdat[FORCE_BIT]))
    else $error("force bit not stored");

  AST_CLEAR_RELEASES: // RULE16
    assert property (grp[G_EDGE].clr[0] && !evt[G_EDGE][0] |=> !status_q[G_EDGE][0] && !raw_q[G_EDGE][0])
    else $error("clear did not release status and raw");

  AST_ACK_SINGLE: // RULE4
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood for two cycles");

  // ==========================================================
  // Register map: read data is the value seen the edge before ack
  AST_READ_VC_STATUS: // RULE5
    assert property (req && !ack_q && idx == STATUS_IDX[G_VC] |=> wb_dat_o[7:0] == $past(status_q[G_VC]))
    else $error("video core status not at its offset");

  AST_READ_CH_STATUS: // RULE5
    assert property (req && !ack_q && idx == STATUS_IDX[G_CH] |=> wb_dat_o[7:0] == $past(status_q[G_CH]))
    else $error("channel status not at its offset");

  AST_READ_MAN_STATUS: // RULE5
    assert property (req && !ack_q && idx == STATUS_IDX[G_MAN] |=> wb_dat_o[7:0] == $past(status_q[G_MAN]))
    else $error("manual status not at its offset");

  AST_READ_LEVEL_STATUS: // RULE6
    assert property (req && !ack_q && idx == STATUS_IDX[G_LVL] |=> wb_dat_o[7:0] == $past(status_q[G_LVL]))
    else $error("level status not at its offset");

  AST_READ_EDGE_STATUS: // RULE7
    assert property (req && !ack_q && idx == STATUS_IDX[G_EDGE] |=> wb_dat_o[7:0] == $past(status_q[G_EDGE]))
    else $error("edge status not at its offset");

  COV_HOLD: cover property (ctrl_q[DUR_LSB+:2] == DUR_SEL_HOLD && $rose(irq_out_pin_o));
  COV_FORCE: cover property (man_evt && mask_q[G_MAN][MANUAL_BIT] ##2 irq_out_pin_o);
  COV_LEVEL: cover property ($rose(status_q[G_LVL][0]));
  COV_CLEAR: cover property ($fell(status_q[G_EDGE][0]));
endmodule

// ---- design/irq_agg_pkg.sv ----
// Constants shared by the interrupt flag aggregator
package irq_agg_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam int         BUS_ADDR_W   = 10;
  localparam logic [7:0] CTRL_IDX     = 8'h40;
  localparam logic [7:0] EDGE_SEL_IDX = 8'h41;
  localparam logic [7:0] RAW_DELTA    = 8'h01;
  localparam logic [7:0] CLR_DELTA    = 8'h01;
  localparam logic [7:0] MASK_DELTA   = 8'h03;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] EDGE_SEL_RST = 8'h30;
  localparam logic [7:0] MASK_RST     = 8'h00;
  // ==========================================================
  // Field positions
  localparam int DUR_LSB       = 6;
  localparam int FORCE_BIT     = 2;
  localparam int SYNC_SEL_BIT  = 4;
  localparam int LOCK_SEL_BIT  = 5;
  localparam int MANUAL_BIT    = 7;
  localparam int LIVE_BIT      = 0;
  localparam int VC_SYNC_BIT   = 4;
  localparam int VC_UNLOCK_BIT = 3;
  localparam int VC_LOCK_BIT   = 2;
  localparam int CH_LOCK_BIT   = 3;
  localparam int CH_UNLOCK_BIT = 2;
  localparam int CH_SYNC_BIT   = 1;
  // ==========================================================
  // Status groups
  localparam int NUM_GROUPS = 14;
  localparam int G_VC       = 0;
  localparam int G_MAN      = 1;
  localparam int G_CH       = 2;
  localparam int G_LVL      = 3;
  localparam int N_LVL      = 4;
  localparam int G_EDGE     = 7;
  localparam int N_EDGE     = 5;
  localparam int G_CEC      = 12;
  localparam int G_CECB     = 13;
  localparam logic [7:0] STATUS_IDX [NUM_GROUPS] = '{8'h43, 8'h48, 8'h5c, 8'h61, 8'h66, 8'h6b, 8'h70,
                                                     8'h7a, 8'h7f, 8'h84, 8'h89, 8'h8e, 8'h93, 8'h98};
  // ==========================================================
  // Interrupt duration, in crystal periods
  localparam logic [1:0] DUR_SEL_4    = 2'h0;
  localparam logic [1:0] DUR_SEL_16   = 2'h1;
  localparam logic [1:0] DUR_SEL_64   = 2'h2;
  localparam logic [1:0] DUR_SEL_HOLD = 2'h3;
  localparam int         DUR_CYC_4    = 4;
  localparam int         DUR_CYC_16   = 16;
  localparam int         DUR_CYC_64   = 64;
endpackage

// ---- design/edge_event_detect.sv ----
// Per-bit edge detector with rising-only or both-edge selection
`timescale 1ns/1ps
module edge_event_detect #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] level_i,
  input  wire logic         both_i,
  output logic      [W-1:0] evt_o
);
  // ==========================================================
  // Checks
  if (W < 1) begin : g_bad_w
    $error("edge_event_detect needs W of at least 1");
  end

  // ==========================================================
  // Detection
  logic [W-1:0] prev_q;
  logic         armed_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= level_i;
    end
  end

  // First sample after reset only arms, so an idle-high level gives no edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  for (genvar b = 0; b < W; b++) begin : g_bit
    assign evt_o[b] = armed_q && ((level_i[b] && !prev_q[b]) || (both_i && !level_i[b] && prev_q[b]));
  end
endmodule

// ---- design/irq_pulse_shaper.sv ----
// Interrupt pin pulse shaper with programmable duration
`timescale 1ns/1ps
module irq_pulse_shaper
  import irq_agg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       pend_i,
  input  wire logic [1:0] dur_i,
  output logic            irq_o
);
  // ==========================================================
  // Checks
  if (DUR_CYC_64 > 128 || DUR_CYC_4 < 1) begin : g_bad_dur
    $error("irq_pulse_shaper counter cannot hold the duration");
  end

  // ==========================================================
  // State
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_HOLD} shaper_state_type;
  shaper_state_type state_q;
  logic [6:0]       cnt_q;
  logic [6:0]       len_m1;
  logic             pend_q;
  logic             start;

  // Only a fresh rise of the pending OR starts a pulse
  assign start = pend_i && !pend_q && state_q == ST_IDLE; // RULE3

  always_comb begin
    case (dur_i)
      DUR_SEL_4:  len_m1 = 7'(DUR_CYC_4 - 1);
      DUR_SEL_16: len_m1 = 7'(DUR_CYC_16 - 1);
      default:    len_m1 = 7'(DUR_CYC_64 - 1);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 7'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start && dur_i == DUR_SEL_HOLD) begin
            state_q <= ST_HOLD; // RULE17
          end else if (start) begin
            state_q <= ST_PULSE;
            cnt_q   <= len_m1; // RULE17
          end
        end
        ST_PULSE: begin
          if (cnt_q == 7'h00) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
        ST_HOLD: begin
          if (!pend_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign irq_o = state_q != ST_IDLE;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_PULSE_4: assert property (start && dur_i == 2'h0 |=> irq_o ##3 irq_o ##1 !irq_o) // RULE17
    else $error("pulse of 4 cycles wrong");
  AST_PULSE_16: assert property (start && dur_i == 2'h1 |=> irq_o ##15 irq_o ##1 !irq_o) // RULE17
    else $error("pulse of 16 cycles wrong");
  AST_PULSE_64: assert property (start && dur_i == 2'h2 |=> irq_o ##63 irq_o ##1 !irq_o) // RULE17
    else $error("pulse of 64 cycles wrong");
  AST_HOLD_TILL_CLEAR: assert property (start && dur_i == 2'h3 ##1 pend_i [*2] |-> irq_o) // RULE17
    else $error("held interrupt dropped while pending");
  AST_NO_RETRIGGER: assert property (!irq_o && pend_q && pend_i |=> !irq_o) // RULE3
    else $error("second assertion while still pending");
endmodule

// ---- test/wb_host_model.sv ----
// Wishbone host model that reaches the aggregator registers
`timescale 1ns/1ps
module wb_host_model
  import irq_agg_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  ack_i,
  input  wire logic [31:0]           dat_i,
  output logic                       cyc_o,
  output logic                       stb_o,
  output logic                       we_o,
  output logic      [BUS_ADDR_W-1:0] adr_o,
  output logic      [3:0]            sel_o,
  output logic      [31:0]           dat_o
);
  // ==========================================================
  // Idle bus
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = '0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // ==========================================================
  // Single cycle, held until ack is sampled high
  task automatic access(input logic we, input logic [7:0] idx, input logic [7:0] wdat,
                        output logic [7:0] rdat);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'h1;
    dat_o <= {24'h0, wdat};
    @(posedge clk_i);
    // Only the bench watchdog ends a wait that never sees ack
    while (ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rdat = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    // Stale data would hide a slave that latches late
    dat_o <= ~dat_o;
  endtask
  // ==========================================================
  // One interrupt may stand for several pending events
  task automatic scan_status(output logic [7:0] any);
    logic [7:0] r;
    any = 8'h00;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      access(1'b0, STATUS_IDX[g], 8'h00, r);
      any = any | r;
    end
  endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the interrupt flag aggregator
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb;
  import irq_agg_pkg::*;
  logic                   clk_i;
  logic                   rst_i;
  logic                   cyc;
  logic                   stb;
  logic                   we;
  logic [BUS_ADDR_W-1:0]  adr;
  logic [3:0]             sel;
  logic [31:0]            wdat;
  logic [31:0]            rdat;
  logic                   ack;
  logic                   sync_valid_i;
  logic                   sync_valid_ch1_i;
  logic                   lock_i;
  logic                   lock_ch1_i;
  logic [N_LVL-1:0][7:0]  hdmi_level_raw_i;
  logic [N_EDGE-1:0][7:0] hdmi_edge_evt_i;
  logic [5:0]             consumer_ctl_evt_i;
  logic [7:0]             consumer_ctl_event_byte_i;
  logic                   irq_out_pin_o;
  logic                   overall_irq_live_o;
  logic [7:0]             idx;
  logic [7:0]             v;
  int                     n_errors;
  int                     checks_done;
  int                     len;
  int                     exp_len [3] = '{DUR_CYC_4, DUR_CYC_16, DUR_CYC_64};

  interrupt_flag_aggregator DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sync_valid_i(sync_valid_i), .sync_valid_ch1_i(sync_valid_ch1_i), .lock_i(lock_i),
    .lock_ch1_i(lock_ch1_i), .hdmi_level_raw_i(hdmi_level_raw_i), .hdmi_edge_evt_i(hdmi_edge_evt_i),
    .consumer_ctl_evt_i(consumer_ctl_evt_i), .consumer_ctl_event_byte_i(consumer_ctl_event_byte_i),
    .irq_out_pin_o(irq_out_pin_o), .overall_irq_live_o(overall_irq_live_o));
  wb_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // ==========================================================
  // Shared tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_host.access(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    u_host.access(1'b0, a, 8'h00, r);
    `CHK($sformatf("reg %h", a), exp, r)
  endtask
  task automatic pulse_len(output int n);
    int w;
    n = 0;
    w = 0;
    while (irq_out_pin_o !== 1'b1 && w < 20) begin
      @(posedge clk_i);
      w++;
    end
    while (irq_out_pin_o === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic set_lines(input logic main_l, input logic ch1_l);
    @(posedge clk_i);
    lock_i           <= main_l;
    sync_valid_i     <= main_l;
    lock_ch1_i       <= ch1_l;
    sync_valid_ch1_i <= ch1_l;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, n_errors);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    final_report();
  end

  // ==========================================================
  // Test sequence
  initial begin
    rst_i = 1'b1;
    {sync_valid_i, sync_valid_ch1_i, lock_i, lock_ch1_i} = 4'h0;
    hdmi_level_raw_i = '0;
    hdmi_edge_evt_i = '0;
    consumer_ctl_evt_i = 6'h00;
    consumer_ctl_event_byte_i = 8'h00;
    n_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(EDGE_SEL_IDX, 8'h30);
    rc(8'h4b, 8'h00);
    rc(CTRL_IDX, 8'h00);
    wr(8'h20, 8'hff);
    rc(8'h20, 8'h00);
    done("reset");
    // Masked off: raw latches, pin stays quiet
    wr(CTRL_IDX, 8'h04);
    rc(CTRL_IDX, 8'h04);
    repeat (8) @(posedge clk_i);
    `CHK("pin", 1'b0, irq_out_pin_o)
    rc(8'h47, 8'h80);
    rc(8'h48, 8'h00);
    wr(8'h49, 8'h80);
    wr(8'h4b, 8'h80);
    for (int d = 0; d < 3; d++) begin
      wr(CTRL_IDX, {d[1:0], 6'h04});
      pulse_len(len);
      `CHK("pulse", exp_len[d], len)
      rc(8'h48, 8'h80);
      `CHK("live", 1'b1, overall_irq_live_o)
      wr(CTRL_IDX, {d[1:0], 6'h04});
      pulse_len(len);
      `CHK("second pulse", 0, len)
      u_host.scan_status(v);
      `CHK("pending", 8'h80, v)
      wr(8'h49, 8'h80);
      rc(8'h48, 8'h00);
      `CHK("live", 1'b0, overall_irq_live_o)
    end
    wr(CTRL_IDX, 8'hc4);
    repeat (100) @(posedge clk_i);
    `CHK("hold", 1'b1, irq_out_pin_o)
    wr(8'h49, 8'h80);
    repeat (3) @(posedge clk_i);
    `CHK("hold end", 1'b0, irq_out_pin_o)
    wr(8'h4b, 8'h00);
    wr(CTRL_IDX, 8'h00);
    done("manual");
    // Lock and sync-valid edges, both then rising only
    wr(8'h46, 8'h14);
    set_lines(1'b1, 1'b0);
    rc(8'h43, 8'h14);
    wr(8'h43, 8'hff);
    rc(8'h43, 8'h14);
    rc(8'h42, 8'h1c);
    wr(8'h44, 8'hff);
    rc(8'h42, 8'h00);
    set_lines(1'b0, 1'b0);
    rc(8'h43, 8'h14);
    wr(8'h44, 8'hff);
    wr(EDGE_SEL_IDX, 8'h00);
    set_lines(1'b1, 1'b0);
    rc(8'h43, 8'h14);
    wr(8'h44, 8'hff);
    set_lines(1'b0, 1'b0);
    rc(8'h43, 8'h00);
    wr(8'h46, 8'h00);
    wr(8'h5f, 8'h0e);
    set_lines(1'b1, 1'b1);
    rc(8'h5c, 8'h0a);
    rc(8'h47, 8'h01);
    wr(8'h5d, 8'hff);
    wr(8'h5f, 8'h00);
    done("edge select");
    // Level groups follow live state
    for (int g = 0; g < N_LVL; g++) begin
      idx = STATUS_IDX[G_LVL + g];
      v = 8'h5a + g[7:0];
      wr(idx + 8'h03, 8'hff);
      @(posedge clk_i);
      hdmi_level_raw_i[g] <= v;
      repeat (3) @(posedge clk_i);
      rc(idx - 8'h01, v);
      rc(idx, v);
      wr(idx + 8'h03, 8'h00);
      hdmi_level_raw_i[g] <= 8'h00;
      repeat (3) @(posedge clk_i);
      rc(idx - 8'h01, 8'h00);
      rc(idx, v);
      wr(idx + 8'h01, 8'hff);
      rc(idx, 8'h00);
    end
    // Edge groups and consumer-control events latch
    for (int g = 0; g < N_EDGE + 2; g++) begin
      idx = STATUS_IDX[G_EDGE + g];
      v = (g == N_EDGE) ? 8'h21 : (8'h80 | (8'h01 << g));
      wr(idx + 8'h03, 8'hff);
      @(posedge clk_i);
      if (g < N_EDGE)
        hdmi_edge_evt_i[g] <= v;
      else if (g == N_EDGE)
        consumer_ctl_evt_i <= v[5:0];
      else
        consumer_ctl_event_byte_i <= v;
      @(posedge clk_i);
      hdmi_edge_evt_i <= '0;
      consumer_ctl_evt_i <= 6'h00;
      consumer_ctl_event_byte_i <= 8'h00;
      rc(idx - 8'h01, v);
      rc(idx, v);
      `CHK("live", 1'b1, overall_irq_live_o)
      rc(idx - 8'h01, v);
      wr(idx + 8'h01, 8'hff);
      rc(idx - 8'h01, 8'h00);
      rc(idx, 8'h00);
      wr(idx + 8'h03, 8'h00);
    end
    done("groups");
    final_report();
  end
endmodule
